// file: hdl/ccie_pkg.sv
// Package for the call and clear instruction execution block.
// Assumes a 14-bit instruction word and a 13-bit program counter.
package ccie_pkg;

    // =========================================================================
    // Widths
    localparam int CCIE_INSTR_W = 14;
    localparam int CCIE_PC_W    = 13;
    localparam int CCIE_DATA_W  = 8;
    localparam int CCIE_FADDR_W = 7;
    localparam int CCIE_LIT_W   = 11;

    // =========================================================================
    // Opcode patterns and field positions
    localparam logic [13:0] CCIE_CLR_ACCUM_CODE   = 14'h0103;
    localparam logic [6:0]  CCIE_CLR_FILE_TOP     = 7'h03;
    localparam int          CCIE_CLR_FILE_TOP_LSB = 7;
    localparam logic [2:0]  CCIE_CALL_TOP    = 3'h4;
    localparam int          CCIE_CALL_TOP_LSB = 11;
    localparam int          CCIE_LATCH_HI    = 4;
    localparam int          CCIE_LATCH_LO    = 3;

    // =========================================================================
    // Reset values and timing
    localparam logic [7:0]  CCIE_ZERO_DATA   = 8'h00;
    localparam logic [12:0] CCIE_PC_RESET    = 13'h0000;
    localparam int          CCIE_CALL_CYCLES = 2;

    // Execution phase of the block.
    typedef enum logic [0:0] {
        CCIE_EXEC,
        CCIE_CALL_WAIT
    } ccie_state_type;

    // Write request toward the register file and accumulator.
    typedef struct packed {
        logic       file_we;
        logic [6:0] file_addr;
        logic [7:0] file_data;
        logic       accum_we;
        logic [7:0] accum_data;
        logic       zero_we;
        logic       zero_val;
    } ccie_wr_type;

    // Request toward the program counter and stack.
    typedef struct packed {
        logic        pc_we;
        logic [12:0] pc_val;
        logic        push;
        logic [12:0] stack_top;
        logic        busy;
    } ccie_flow_type;

endpackage

// file: hdl/ccie_decode.sv
// Pure decoder of the three handled instruction classes.
// Assumes the instruction word is stable during the cycle it is offered.
`timescale 1ns/100ps
module ccie_decode
    import ccie_pkg::*;
(
    // Instruction word
    input  wire logic [13:0] instr,
    // Decoded classes
    output logic             is_clr_file,
    output logic             is_clr_accum,
    output logic             is_call
);

    // =========================================================================
    // Decoding
    // Each class is matched against its fixed opcode bits.
    always_comb begin
        is_clr_file  = (instr[13:CCIE_CLR_FILE_TOP_LSB] == CCIE_CLR_FILE_TOP);
        is_clr_accum = (instr == CCIE_CLR_ACCUM_CODE);
        is_call      = (instr[13:CCIE_CALL_TOP_LSB] == CCIE_CALL_TOP);
    end

endmodule

// file: hdl/ccie_top.sv
// Execution of clear-register, clear-accumulator and subroutine-call.
// Assumes instructions arrive with instr_valid once per instruction cycle
// and that the core does not offer a new one while busy is high.
`timescale 1ns/100ps
module ccie_top
    import ccie_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Instruction in
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    input  wire logic [12:0] pc_cur,
    input  wire logic [7:0]  pc_upper_latch,
    // Data side
    output ccie_wr_type      wr_req,
    // Program flow side
    output ccie_flow_type    flow_req
);

    // Whole state of the block.
    typedef struct packed {
        ccie_state_type state;
        ccie_wr_type    wr;
        ccie_flow_type  flow;
    } ccie_all_type;

    ccie_all_type st_reg;
    ccie_all_type st_next;
    logic         rst_meta_reg;
    logic         rst_sync_reg;
    logic         rst_n;
    logic         is_clr_file;
    logic         is_clr_accum;
    logic         is_call;

    // =========================================================================
    // Reset release
    // Reset asserts at once and releases through two flip-flops.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // =========================================================================
    // Decoder
    ccie_decode u_dec (
        .instr   (instr),
        .is_clr_file  (is_clr_file),
        .is_clr_accum (is_clr_accum),
        .is_call      (is_call)
    );

    // =========================================================================
    // Next state
    // Requests are one-cycle strobes but pc_val and stack_top hold; a call holds busy with its push, one cycle before the PC load.
    always_comb begin
        st_next            = st_reg;
        st_next.wr         = '0;
        st_next.flow.pc_we = 1'b0;
        st_next.flow.push  = 1'b0;
        st_next.flow.busy  = 1'b0;
        case (st_reg.state)
            CCIE_EXEC: begin
                if (instr_valid && is_clr_file) begin
                    st_next.wr.file_we   = 1'b1;
                    st_next.wr.file_addr = instr[6:0];
                    st_next.wr.file_data = CCIE_ZERO_DATA;
                    st_next.wr.zero_we   = 1'b1;
                    st_next.wr.zero_val  = 1'b1;
                end else if (instr_valid && is_clr_accum) begin
                    st_next.wr.accum_we   = 1'b1;
                    st_next.wr.accum_data = CCIE_ZERO_DATA;
                    st_next.wr.zero_we    = 1'b1;
                    st_next.wr.zero_val   = 1'b1;
                end else if (instr_valid && is_call) begin
                    // Push happens in the first cycle, PC load in the second.
                    st_next.flow.push      = 1'b1;
                    st_next.flow.stack_top = 13'(pc_cur + 13'h0001);
                    st_next.flow.pc_val    = {pc_upper_latch[CCIE_LATCH_HI:CCIE_LATCH_LO],
                                              instr[10:0]};
                    st_next.flow.busy      = 1'b1;
                    st_next.state          = CCIE_CALL_WAIT;
                end
            end
            CCIE_CALL_WAIT: begin
                st_next.flow.pc_we = 1'b1;
                st_next.state      = CCIE_EXEC;
            end
            default: begin
                st_next.state = CCIE_EXEC;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{state: CCIE_EXEC, wr: '0,
                        flow: '{pc_we: 1'b0, pc_val: CCIE_PC_RESET, push: 1'b0,
                                stack_top: CCIE_PC_RESET, busy: 1'b0}};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register.
    assign wr_req   = st_reg.wr;
    assign flow_req = st_reg.flow;

    // =========================================================================
    // Checks
    // A register clear zeroes the addressed register and sets zero.
    property p_clr_file_zero;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && is_clr_file && st_reg.state == CCIE_EXEC) |=>
            (wr_req.file_we && wr_req.file_data == 8'h00 && wr_req.zero_val
             && wr_req.file_addr == $past(instr[6:0]));
    endproperty
    a_clr_file_zero: assert property (p_clr_file_zero) else $error("file clear bad");

    // An accumulator clear loads zero and sets the zero flag.
    property p_clr_accum_zero;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && is_clr_accum && st_reg.state == CCIE_EXEC) |=>
            (wr_req.accum_we && wr_req.accum_data == 8'h00 && wr_req.zero_we
             && wr_req.zero_val);
    endproperty
    a_clr_accum_zero: assert property (p_clr_accum_zero) else $error("accum clear bad");

    // The return address is pushed one cycle before the counter write.
    property p_push_first;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && is_call && st_reg.state == CCIE_EXEC) |=>
            (flow_req.push && !flow_req.pc_we
             && flow_req.stack_top == 13'($past(pc_cur) + 13'h0001))
            ##1 (flow_req.pc_we && !flow_req.push);
    endproperty
    a_push_first: assert property (p_push_first) else $error("push order wrong");

    // The counter is written only after a push, with both values held.
    property p_pc_after_push;
        @(posedge clk) disable iff (!rst_n)
        flow_req.pc_we |-> ($past(flow_req.push) && $stable(flow_req.pc_val)
                            && $stable(flow_req.stack_top));
    endproperty
    a_pc_after_push: assert property (p_pc_after_push) else $error("pc written early");

    // The literal lands in the low counter bits by the write cycle.
    property p_lit_low;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && is_call && st_reg.state == CCIE_EXEC) |=>
            ##1 (flow_req.pc_val[10:0] == $past(instr[10:0], 2));
    endproperty
    a_lit_low: assert property (p_lit_low) else $error("literal not loaded");

    // The two latch bits form the top of the call target.
    property p_latch_hi;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && is_call && st_reg.state == CCIE_EXEC) |=>
            (flow_req.pc_val[12:11] == $past(pc_upper_latch[4:3]));
    endproperty
    a_latch_hi: assert property (p_latch_hi) else $error("upper bits wrong");

    // A call is busy for one cycle and writes the counter in the next.
    property p_two_cycles;
        @(posedge clk) disable iff (!rst_n)
        $rose(flow_req.busy) |-> flow_req.busy ##1 (!flow_req.busy && flow_req.pc_we);
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("call length wrong");

    // Busy stands only together with the push of the first call cycle.
    property p_busy_with_push;
        @(posedge clk) disable iff (!rst_n)
        flow_req.busy |-> (flow_req.push && !flow_req.pc_we);
    endproperty
    a_busy_with_push: assert property (p_busy_with_push) else $error("busy misplaced");

    // An offer during the first call cycle, while busy, is dropped without effect.
    property p_busy_refuse;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && st_reg.state == CCIE_CALL_WAIT) |=>
            (!wr_req.file_we && !wr_req.accum_we && !wr_req.zero_we && !flow_req.push);
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("busy offer taken");

    // A clear finishes in one cycle and never touches the program flow.
    property p_one_cycle;
        @(posedge clk) disable iff (!rst_n)
        (instr_valid && (is_clr_file || is_clr_accum) && st_reg.state == CCIE_EXEC) |=>
            (wr_req.zero_we && (wr_req.file_we != wr_req.accum_we) && !flow_req.busy
             && !flow_req.push && !flow_req.pc_we);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("clear not single cycle");

    // A zero write only follows an instruction offered one cycle before.
    property p_zero_traced;
        @(posedge clk) disable iff (!rst_n)
        wr_req.zero_we |-> ($past(instr_valid) && wr_req.zero_val);
    endproperty
    a_zero_traced: assert property (p_zero_traced) else $error("stray zero write");

    // Call cycles never write data or the zero flag.
    property p_call_no_flags;
        @(posedge clk) disable iff (!rst_n)
        (flow_req.push || flow_req.pc_we) |-> (!wr_req.zero_we && !wr_req.file_we
                                               && !wr_req.accum_we);
    endproperty
    a_call_no_flags: assert property (p_call_no_flags) else $error("call touched data");

endmodule

// file: testbench/tb_top.sv
// Self-checking testbench for the call and clear instruction execution block.
// Assumes the package and design files under hdl/ are compiled before it.
`timescale 1ns/100ps
module tb_top
    import ccie_pkg::*;
;
    // ========================================================================
    // Stimulus and observation signals
    logic          clk;
    logic          nrst;
    logic          instr_valid;
    logic [13:0]   instr;
    logic [12:0]   pc_cur;
    logic [7:0]    pc_upper_latch;
    ccie_wr_type   wr_req;
    ccie_flow_type flow_req;
    int            fails;
    int            compares;

    // Device under test.
    ccie_top u_dut (
        .clk            (clk),
        .nrst           (nrst),
        .instr_valid    (instr_valid),
        .instr          (instr),
        .pc_cur         (pc_cur),
        .pc_upper_latch (pc_upper_latch),
        .wr_req         (wr_req),
        .flow_req       (flow_req)
    );

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ========================================================================
    // Shared tasks
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Compares file, accumulator, zero, program counter and push strobes.
    task automatic strb(input logic [4:0] exp);
        chk({wr_req.file_we, wr_req.accum_we, wr_req.zero_we, flow_req.pc_we, flow_req.push},
            exp, "strobes");
    endtask

    // Offers one instruction at a falling edge and waits one cycle; valid stays up.
    task automatic issue(input logic [13:0] i, input logic [12:0] pc, input logic [7:0] lt);
        instr_valid = 1'b1;
        instr = i;
        pc_cur = pc;
        pc_upper_latch = lt;
        @(negedge clk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ========================================================================
    // Scenarios
    // Back-to-back register clears at both ends of the address range.
    task automatic t_clear();
        logic [6:0] f [3] = '{7'h00, 7'h55, 7'h7F};
        for (int n = 0; n < 3; n++) begin
            issue({7'h03, f[n]}, 13'h0010, 8'h00);
            strb(5'h14);
            chk(wr_req.file_addr, f[n], "file address");
            chk(wr_req.file_data, 8'h00, "file data");
            chk(wr_req.zero_val, 1'h1, "zero value");
        end
        issue(14'h0103, 13'h0011, 8'h00);
        instr_valid = 1'b0;
        strb(5'h0C);
        chk(wr_req.accum_data, 8'h00, "accumulator data");
        chk(wr_req.zero_val, 1'h1, "zero value");
        @(negedge clk);
        strb(5'h00);
        $display("clear test done");
    endtask

    // A call with a clear offered while busy, which must be ignored.
    task automatic t_call(input logic [12:0] pc, input logic [7:0] lt, input logic [10:0] k,
                          input logic [12:0] top, input logic [12:0] tgt);
        issue({3'h4, k}, pc, lt);
        instr = 14'h0103;
        strb(5'h01);
        chk(flow_req.busy, 1'h1, "busy");
        chk(flow_req.stack_top, top, "return address");
        @(negedge clk);
        instr_valid = 1'b0;
        strb(5'h02);
        chk(flow_req.pc_val, tgt, "call target");
        chk(flow_req.busy, 1'h0, "busy");
        @(negedge clk);
        strb(5'h00);
        $display("call test done");
    endtask

    // Neighbouring opcodes must produce nothing.
    task automatic t_other();
        logic [13:0] c [5] = '{14'h0000, 14'h2800, 14'h0080, 14'h3000, 14'h0980};
        for (int n = 0; n < 5; n++) begin
            issue(c[n], 13'h0020, 8'h18);
            strb(5'h00);
            chk(flow_req.busy, 1'h0, "busy");
        end
        instr_valid = 1'b0;
        $display("other opcode test done");
    endtask

    // ========================================================================
    // Main sequence: reset, then every scenario.
    initial begin
        fails = 0;
        compares = 0;
        nrst = 1'b0;
        instr_valid = 1'b0;
        instr = 14'h0000;
        pc_cur = 13'h0000;
        pc_upper_latch = 8'h00;
        repeat (4) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        chk(32'(wr_req), 32'h0, "reset data outputs");
        chk(32'(flow_req), 32'h0, "reset flow outputs");
        t_clear();
        t_call(13'h1FFF, 8'hF7, 11'h555, 13'h0000, 13'h1555);
        t_call(13'h0123, 8'h08, 11'h000, 13'h0124, 13'h0800);
        t_call(13'h0FFF, 8'h18, 11'h7FF, 13'h1000, 13'h1FFF);
        t_other();
        complete_run();
    end

    // Watchdog: the scenarios need well under 100 cycles.
    initial begin
        #40000;
        fails++;
        complete_run();
    end
endmodule
